/* dv/test_rotate_and_return_execution.sv */
// Purpose: self-checking bench for rar_exec against an integer model
// Assumes: stimulus never pops an empty stack nor overfills it
// Notes:   random mix of rotates, returns, pushes and foreign opcodes
`timescale 1ns/1ps
`default_nettype none
`include "rar_cfg.svh"
module test_rotate_and_return_execution;
  import rar_pkg::*;
  logic      clk_i, rstn_i, instr_valid_i, push_i, chk_en;
  rar_word_t instr_i, instr_addr_i, push_addr_i, pc_o;
  rar_byte_t file_rdata_i, file_addr_o, file_wdata_o, working_register_o, hi_latch;
  logic      file_we_o, carry_o, pc_load_o, forced_nop_o;
  int        n_fail = 0, checked = 0, k, stk[$];
  int        working_register, c, pc, lat, fa, fd, we_e, ld_e, nop_m;
  rar_exec #(.STACK_DEPTH(16)) dut_u (.clk_i(clk_i), .rstn_i(rstn_i),
    .instr_valid_i(instr_valid_i), .instr_i(instr_i), .instr_addr_i(instr_addr_i),
    .file_rdata_i(file_rdata_i), .push_i(push_i), .push_addr_i(push_addr_i),
    .file_we_o(file_we_o), .file_addr_o(file_addr_o), .file_wdata_o(file_wdata_o),
    .working_register_o(working_register_o), .carry_o(carry_o), .pc_o(pc_o),
    .pc_load_o(pc_load_o), .program_counter_high_latch_o(hi_latch),
    .forced_nop_o(forced_nop_o));
  // ----------------------------------------------------------------
  // reporting
  // ----------------------------------------------------------------
  task automatic chk(input logic [15:0] got, input int exp);
    checked++;
    if (got !== exp[15:0]) begin
      n_fail++;
      $display("mismatch at %0t: got %h expected %h", $time, got, exp[15:0]);
    end
  endtask : chk
  task automatic tally_and_finish;
    $display("checks %0d failures %0d", checked, n_fail);
    if (n_fail == 0 && checked > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask : tally_and_finish
  // ----------------------------------------------------------------
  // one issue cycle: drive at the edge, model the edge that takes it
  // ----------------------------------------------------------------
  task automatic cyc(input logic v, input logic [15:0] op, input logic [7:0] rd,
                     input logic pu);
    logic [15:0] a;
    logic [15:0] pa;
    logic        tk;
    logic        rt;
    a = 16'($urandom);
    pa = 16'($urandom);
    instr_valid_i <= v;
    instr_i <= op;
    instr_addr_i <= a;
    file_rdata_i <= rd;
    push_i <= pu;
    push_addr_i <= pa;
    @(posedge clk_i);
    tk = v && !nop_m[0];
    rt = tk && op == `RAR_RET_OP;
    we_e = 0;
    ld_e = 0;
    if (tk && op[15:9] == `RAR_RLC_OP) begin
      fd = {rd[6:0], c[0]};
      c = rd[7];
      if (op[`RAR_DEST_BIT]) begin
        we_e = 1;
        fa = op[7:0];
      end else working_register = fd;
    end
    if (rt) begin
      pc = stk.pop_back();
      ld_e = 1;
      lat = a[15:8];
    end
    // a push colliding with a return or the forced nop is lost
    if (pu && !nop_m[0] && !rt) stk.push_back(pa);
    nop_m = rt;
  endtask : cyc
  // ----------------------------------------------------------------
  // compare the settled outputs against the model, file address and data only when a write is expected
  // ----------------------------------------------------------------
  always @(negedge clk_i) begin
    if (chk_en) begin
      chk(working_register_o, working_register);
      chk(carry_o, c);
      chk(file_we_o, we_e);
      if (we_e != 0) chk(file_addr_o, fa);
      if (we_e != 0) chk(file_wdata_o, fd);
      chk(pc_o, pc);
      chk(pc_load_o, ld_e);
      chk(hi_latch, lat);
      chk(forced_nop_o, nop_m);
    end
  end
  initial begin
    clk_i = 1'b0;
    forever #50 clk_i = ~clk_i;
  end
  initial begin
    repeat (2000) @(posedge clk_i);
    n_fail++;
    tally_and_finish();
  end
  initial begin
    {rstn_i, instr_valid_i, push_i, chk_en} = 4'h0;
    {instr_i, instr_addr_i, push_addr_i, file_rdata_i} = 56'h0;
    void'($urandom(12703));
    repeat (4) @(posedge clk_i);
    rstn_i <= 1'b1;
    chk_en = 1'b1;
    repeat (500) begin
      k = $urandom_range(0, 9);
      // returns only when the model stack holds an entry
      if (k < 5) cyc(k != 0, {`RAR_RLC_OP, k[0], 8'($urandom)}, 8'($urandom),
                     $urandom_range(0, 2) == 0 && stk.size() < 16);
      else if (k < 8 && stk.size() > 0) cyc(1'b1, `RAR_RET_OP, 8'($urandom), k == 7);
      else cyc(k[0], 16'($urandom) | 16'h0100, 8'($urandom), stk.size() < 16);
    end
    @(negedge clk_i);
    #1;
    tally_and_finish();
  end
endmodule : test_rotate_and_return_execution
`default_nettype wire

/* logic/rar_cfg.svh */
// Purpose: constants for the rotate-and-return execution slice
// Assumes: 16-bit opcodes, 8-bit data, 16-bit program counter
// Notes:   definitions only
`ifndef RAR_CFG_SVH
`define RAR_CFG_SVH

// ----------------------------------------------------------------
// opcode patterns
// ----------------------------------------------------------------
`define RAR_RLC_OP      7'h0d
`define RAR_RLC_OP_MSB  15
`define RAR_RLC_OP_LSB  9
`define RAR_DEST_BIT    8
`define RAR_RET_OP      16'h0002

// ----------------------------------------------------------------
// reset values
// ----------------------------------------------------------------
`define RAR_BYTE_RST    8'h00
`define RAR_WORD_RST    16'h0000
`define RAR_CARRY_RST   1'b0

`endif

/* logic/rar_exec.sv */
// Purpose: executes rotate-left-through-carry and subroutine return
// Assumes: one clk_i edge per instruction cycle; file_rdata_i holds the
//          register addressed by instr_i[7:0] in the cycle of issue
// Notes:   the stack is filled from outside by the call logic (push_i)
`timescale 1ns/1ps
`default_nettype none
`include "rar_cfg.svh"

// Behaviour
// - rotate-left-through-carry shifts the file register left, old carry into bit 0, old bit 7 into carry.
// - with the destination bit clear the result goes to working_register and the file is untouched.
// - with the destination bit set the result is written back to the same file register.
// - return loads program_counter_high_latch with the return instruction's high address byte, instr_addr_i[15:8].
// - return pops the stack and loads the program counter from stack_top_w, opcode 0x0002.
module rar_exec #(
  parameter int STACK_DEPTH = 16
) (
  // clock and reset
  input  wire logic          clk_i,
  input  wire logic          rstn_i,
  // instruction issue
  input  wire logic          instr_valid_i,
  input  wire rar_pkg::rar_word_t instr_i,
  input  wire rar_pkg::rar_word_t instr_addr_i,
  input  wire rar_pkg::rar_byte_t file_rdata_i,
  // stack push from call logic
  input  wire logic          push_i,
  input  wire rar_pkg::rar_word_t push_addr_i,
  // file register write port
  output logic               file_we_o,
  output rar_pkg::rar_byte_t file_addr_o,
  output rar_pkg::rar_byte_t file_wdata_o,
  // core state
  output rar_pkg::rar_byte_t working_register_o,
  output logic               carry_o,
  output rar_pkg::rar_word_t pc_o,
  output logic               pc_load_o,
  output rar_pkg::rar_byte_t program_counter_high_latch_o,
  output logic               forced_nop_o
);
  import rar_pkg::*;

  localparam int PW = $clog2(STACK_DEPTH);

  // ----------------------------------------------------------------
  // state
  // ----------------------------------------------------------------
  rar_state_t        state_r, state_nxt;
  logic              file_we_r, file_we_nxt;
  rar_byte_t         file_addr_r, file_addr_nxt;
  rar_byte_t         file_wdata_r, file_wdata_nxt;
  rar_byte_t         working_register_r, working_register_nxt;
  logic              carry_r, carry_nxt;
  rar_word_t         pc_r, pc_nxt;
  logic              pc_load_r, pc_load_nxt;
  rar_byte_t         program_counter_high_latch_r, program_counter_high_latch_nxt;
  logic              nop_r, nop_nxt;
  logic [PW-1:0]     sp_r, sp_nxt;
  rar_word_t         stack_r [STACK_DEPTH];

  // ----------------------------------------------------------------
  // decode
  // ----------------------------------------------------------------
  logic              fire_w;
  logic              is_rlc_w;
  logic              is_ret_w;
  rar_byte_t         rot_w;
  rar_word_t         stack_top_w;
  logic [PW-1:0]     sp_dec_w;
  logic [PW-1:0]     sp_inc_w;

  assign fire_w      = instr_valid_i && (state_r == RAR_RUN);
  assign is_rlc_w    = fire_w && (instr_i[`RAR_RLC_OP_MSB:`RAR_RLC_OP_LSB] == `RAR_RLC_OP);
  assign is_ret_w    = fire_w && (instr_i == `RAR_RET_OP);
  assign rot_w       = {file_rdata_i[6:0], carry_r};
  assign sp_dec_w    = sp_r - {{(PW-1){1'b0}}, 1'b1};
  assign sp_inc_w    = sp_r + {{(PW-1){1'b0}}, 1'b1};
  assign stack_top_w = stack_r[sp_dec_w];

  always_comb begin
    state_nxt      = RAR_RUN;
    file_we_nxt    = 1'b0;
    file_addr_nxt  = file_addr_r;
    file_wdata_nxt = file_wdata_r;
    working_register_nxt       = working_register_r;
    carry_nxt      = carry_r;
    pc_nxt         = pc_r;
    pc_load_nxt    = 1'b0;
    program_counter_high_latch_nxt     = program_counter_high_latch_r;
    sp_nxt         = sp_r;
    nop_nxt        = 1'b0;
    case (state_r)
      RAR_RUN: begin
        if (is_rlc_w) begin
          carry_nxt = file_rdata_i[7];
          if (instr_i[`RAR_DEST_BIT]) begin
            file_we_nxt    = 1'b1;
            file_addr_nxt  = instr_i[7:0];
            file_wdata_nxt = rot_w;
          end else begin
            working_register_nxt = rot_w;
          end
        end else if (is_ret_w) begin
          program_counter_high_latch_nxt  = instr_addr_i[15:8];
          pc_nxt      = stack_top_w;
          pc_load_nxt = 1'b1;
          sp_nxt      = sp_dec_w;
          state_nxt   = RAR_NOP;
          nop_nxt     = 1'b1;
        end
        // a push shares the cycle with a rotate; only a return takes its slot
        if (push_i && !is_ret_w) begin
          sp_nxt = sp_inc_w;
        end
      end
      // second cycle of return: issue is ignored, fetch refills from pc_o
      RAR_NOP: state_nxt = RAR_RUN;
      default: state_nxt = RAR_RUN;
    endcase
  end

  always_ff @(posedge clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      state_r      <= RAR_RUN;
      file_we_r    <= 1'b0;
      file_addr_r  <= `RAR_BYTE_RST;
      file_wdata_r <= `RAR_BYTE_RST;
      working_register_r       <= `RAR_BYTE_RST;
      carry_r      <= `RAR_CARRY_RST;
      pc_r         <= `RAR_WORD_RST;
      pc_load_r    <= 1'b0;
      program_counter_high_latch_r     <= `RAR_BYTE_RST;
      nop_r        <= 1'b0;
      sp_r         <= '0;
    end else begin
      state_r      <= state_nxt;
      file_we_r    <= file_we_nxt;
      file_addr_r  <= file_addr_nxt;
      file_wdata_r <= file_wdata_nxt;
      working_register_r       <= working_register_nxt;
      carry_r      <= carry_nxt;
      pc_r         <= pc_nxt;
      pc_load_r    <= pc_load_nxt;
      program_counter_high_latch_r     <= program_counter_high_latch_nxt;
      nop_r        <= nop_nxt;
      sp_r         <= sp_nxt;
    end
  end

  // ----------------------------------------------------------------
  // stack storage, circular when STACK_DEPTH is a power of two: overflow overwrites the oldest entry
  // ----------------------------------------------------------------
  generate
    for (genvar i = 0; i < STACK_DEPTH; i++) begin : g_stk
      always_ff @(posedge clk_i) begin
        if (push_i && !is_ret_w && (state_r == RAR_RUN) && (sp_r == PW'(i)))
          stack_r[i] <= push_addr_i;
      end
    end
  endgenerate

  assign file_we_o                    = file_we_r;
  assign file_addr_o                  = file_addr_r;
  assign file_wdata_o                 = file_wdata_r;
  assign working_register_o           = working_register_r;
  assign carry_o                      = carry_r;
  assign pc_o                         = pc_r;
  assign pc_load_o                    = pc_load_r;
  assign program_counter_high_latch_o = program_counter_high_latch_r;
  assign forced_nop_o                 = nop_r;

  // ----------------------------------------------------------------
  // checks
  // ----------------------------------------------------------------
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (!rstn_i);

  logic              rlc_wr_w;
  logic              rlc_wk_w;
  logic              old_b7_w;
  rar_byte_t         f_addr_w;
  rar_byte_t         ret_hi_w;
  logic              push_ok_w;
  assign rlc_wr_w = is_rlc_w && instr_i[`RAR_DEST_BIT];
  assign rlc_wk_w = is_rlc_w && !instr_i[`RAR_DEST_BIT];
  assign old_b7_w = file_rdata_i[7];
  assign f_addr_w = instr_i[7:0];
  assign ret_hi_w = instr_addr_i[15:8];
  assign push_ok_w = push_i && !is_ret_w && (state_r == RAR_RUN);

  sequence s_ret_issue;
    is_ret_w;
  endsequence
  sequence s_ret_tail;
    (forced_nop_o && pc_load_o && !file_we_o) ##1 (!forced_nop_o && !pc_load_o);
  endsequence

  AST_RLC_CARRY: assert property (is_rlc_w |=> carry_o == $past(old_b7_w))
    else $error("carry not taken from old bit 7");
  AST_RLC_WORKING_REGISTER: assert property (rlc_wk_w |=> working_register_o == $past(rot_w) && !file_we_o)
    else $error("rotate to working register wrong");
  AST_RLC_FILE: assert property (rlc_wr_w |=> file_we_o && file_wdata_o == $past(rot_w)
                                 && file_addr_o == $past(f_addr_w)
                                 && $stable(working_register_o))
    else $error("rotate write-back wrong");
  AST_RET_LATCH: assert property (is_ret_w |=> program_counter_high_latch_o == $past(ret_hi_w))
    else $error("high latch not refreshed by return");
  AST_RET_PC: assert property (is_ret_w |=> pc_o == $past(stack_top_w))
    else $error("pc not loaded from stack top");
  AST_RET_NOP: assert property (s_ret_issue |=> s_ret_tail)
    else $error("return not followed by one forced nop");
  AST_RET_SP: assert property (is_ret_w |=> sp_r == $past(sp_dec_w))
    else $error("return did not pop the stack");
  AST_PUSH_SP: assert property (push_ok_w |=> sp_r == $past(sp_inc_w))
    else $error("push did not advance the stack");
  AST_PC_HOLD: assert property (!is_ret_w |=> $stable(pc_o))
    else $error("pc moved without a return");
  AST_FILE_QUIET: assert property (!rlc_wr_w |=> !file_we_o)
    else $error("file write without a rotate write-back");
  AST_NOP_IGNORE: assert property (forced_nop_o |=> !pc_load_o && !file_we_o
                                   && $stable(carry_o) && $stable(working_register_o))
    else $error("issue not ignored in the forced nop");
endmodule : rar_exec
`default_nettype wire

/* logic/rar_pkg.sv */
// Purpose: shared types for the rotate-and-return execution slice
// Assumes: nothing beyond the cfg header
// Notes:   types only, constants live in rar_cfg.svh
package rar_pkg;
  typedef logic [7:0]  rar_byte_t;
  typedef logic [15:0] rar_word_t;
  typedef enum logic {RAR_RUN, RAR_NOP} rar_state_t;
endpackage : rar_pkg
